// >>> src/pcs_capture.sv
// Contract
// [R1] sample-rate timer fires a periodic trigger at 8000 Hz
// [R2] each timer trigger starts exactly one conversion
// [R3] conversions use the 12-bit converter, channel 0 only
// [R4] conversion-complete activates one transfer moving that sample
// [R5] repeat mode, 256 words, then destination restarts at buffer start
// [R6] each transfer moves one 16-bit unit
// [R7] source fixed at 0x00089020, destination from 0x00004000 incrementing
// [R8] transfer interrupt request raised after every completed transfer
// [R9] event linker gives one count event per completed conversion
// [R10] event counter signals compare match when count reaches 128
// [R11] compare-match interrupt sets first-half ready flag
// [R12] overflow interrupt sets second-half ready flag
// [R13] transfer addresses are full 32 bits
// [R14] transfer info read before each transfer; no chaining
// [R15] software starts sampling once everything is configured
// [R16] capture runs continuously with no end condition
// [R17] software consumes each half after 128 new samples
// [R18] software may pause sampling temporarily
// [R19] timer compare-match A is the conversion start request
// [R20] 8-bit event counter, no clear on match, overflows every 256
// [R21] first half is words 0-127, second half words 128-255
//
// The APB register port and the register offsets were chosen for this implementation.
`include "pcs_params.svh"
`default_nettype none

module pcs_capture #(
    parameter int unsigned PERIOD_CYCLES = `PCS_PERIOD_CYCLES
) (
    // clock and reset
    input  wire logic            clock_i,
    input  wire logic            rst_b_i,
    // apb slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [11:0]     paddr_i,
    input  wire pcs_pkg::pcs_word_t pwdata_i,
    output logic                 pready_o,
    output pcs_pkg::pcs_word_t   prdata_o,
    output logic                 pslverr_o,
    // converter
    output logic                 conv_start_o,
    output logic [3:0]           conv_chan_o,
    input  wire logic            conv_done_i,
    input  wire logic [11:0]     conv_data_i,
    // ram write port
    output logic                 mem_wr_o,
    output pcs_pkg::pcs_word_t   mem_addr_o,
    output pcs_pkg::pcs_word_t   mem_src_addr_o,
    output pcs_pkg::pcs_half_t   mem_wdata_o,
    input  wire logic            mem_ready_i,
    // interrupt requests and half-ready flags to the processor
    output logic                 xfer_irq_o,
    output logic                 half_full_match_irq_o,
    output logic                 buffer_wrap_irq_o,
    output logic                 first_half_ready_o,
    output logic                 second_half_ready_o
);
    import pcs_pkg::*;

    localparam int unsigned TW = $clog2(PERIOD_CYCLES);

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    logic            enable_q;
    logic [TW-1:0]   timer_q;
    logic            tick;
    logic            conv_start_q;
    pcs_xfer_state_t xf_q;
    logic [7:0]      idx_q;
    pcs_word_t       dst_base_q;
    pcs_half_t       sample_q;
    logic            mem_wr_q;
    pcs_word_t       mem_addr_q;
    logic            xfer_irq_q;
    logic            link_ev_q;
    logic [7:0]      ev_cnt_q;
    logic            match_q;
    logic            wrap_q;
    logic            first_q;
    logic            second_q;
    logic            pready_q;
    pcs_word_t       prdata_q;
    logic            pslverr_q;
    logic            acc;
    logic            wr_acc;
    logic            mapped;
    logic            xfer_done;
    logic            clr_first;
    logic            clr_second;

    // apb: one wait state, write takes effect on the completing edge
    assign acc    = psel_i && penable_i && !pready_q;
    assign wr_acc = psel_i && penable_i && pready_q && pwrite_i;
    assign mapped = reg_hit(paddr_i, `PCS_CTRL_OFS) || reg_hit(paddr_i, `PCS_STAT_OFS)
                 || reg_hit(paddr_i, `PCS_COUNT_OFS) || reg_hit(paddr_i, `PCS_DST_OFS)
                 || reg_hit(paddr_i, `PCS_SRC_OFS);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= acc;
            pslverr_q <= acc && !mapped;
            if (acc && !pwrite_i)
            begin
                prdata_q <= 32'h0000_0000;
                if (reg_hit(paddr_i, `PCS_CTRL_OFS))
                    prdata_q[`PCS_CTRL_EN_BIT] <= enable_q;
                if (reg_hit(paddr_i, `PCS_STAT_OFS))
                begin
                    prdata_q[`PCS_STAT_FIRST_BIT]  <= first_q;
                    prdata_q[`PCS_STAT_SECOND_BIT] <= second_q;
                end
                if (reg_hit(paddr_i, `PCS_COUNT_OFS))
                    prdata_q[15:0] <= {ev_cnt_q, idx_q};
                if (reg_hit(paddr_i, `PCS_DST_OFS))
                    prdata_q <= dst_base_q;
                if (reg_hit(paddr_i, `PCS_SRC_OFS))
                    prdata_q <= `PCS_SRC_ADDR;
            end
        end
    end

    // [R15] software start
    // [R18] pause by clearing enable
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            enable_q <= 1'(`PCS_CTRL_RST);
        else if (wr_acc && reg_hit(paddr_i, `PCS_CTRL_OFS))
            enable_q <= pwdata_i[`PCS_CTRL_EN_BIT];
    end

    // destination base only changes while enable is clear so a transfer never splits
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            dst_base_q <= `PCS_DST_ADDR;
        else if (wr_acc && reg_hit(paddr_i, `PCS_DST_OFS) && !enable_q)
            dst_base_q <= pwdata_i;
    end

    // [R1] period counter
    // [R16] free running while enabled
    assign tick = enable_q && (timer_q == TW'(PERIOD_CYCLES - 1));

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            timer_q <= '0;
        else if (!enable_q || tick)
            timer_q <= '0;
        else
            timer_q <= timer_q + TW'(1);
    end

    // [R19] compare-match start request
    // [R2] one start per trigger
    // [R3] channel zero
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            conv_start_q <= 1'b0;
        else
            conv_start_q <= tick;
    end

    // [R4] activation by conversion-complete
    // [R14] descriptor fetch every transfer
    assign xfer_done = (xf_q == PCS_XF_WRITE) && mem_ready_i;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            xf_q       <= PCS_XF_IDLE;
            sample_q   <= 16'h0000;
        end
        else
        begin
            unique case (xf_q)
                PCS_XF_IDLE:
                begin
                    if (conv_done_i)
                    begin
                        // [R6] one 16-bit unit
                        sample_q <= {4'h0, conv_data_i};
                        xf_q     <= PCS_XF_FETCH;
                    end
                end
                PCS_XF_FETCH:
                    xf_q <= PCS_XF_WRITE;
                PCS_XF_WRITE:
                begin
                    if (mem_ready_i)
                        xf_q <= PCS_XF_IDLE;
                end
                default:
                    xf_q <= PCS_XF_IDLE;
            endcase
        end
    end

    // [R7] fixed source, incrementing destination
    // [R13] 32-bit address
    // [R21] halves by word index
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_wr_q   <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
        end
        else if (xf_q == PCS_XF_FETCH)
        begin
            mem_wr_q   <= 1'b1;
            mem_addr_q <= dst_base_q + {23'h0, idx_q, 1'b0};
        end
        else if (xfer_done)
            mem_wr_q <= 1'b0;
    end

    // [R5] repeat wraps after 256
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            idx_q <= 8'h00;
        else if (xfer_done)
            idx_q <= idx_q + 8'h01;
    end

    // [R8] interrupt per transfer
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            xfer_irq_q <= 1'b0;
        else
            xfer_irq_q <= xfer_done;
    end

    // [R9] event linker stage
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            link_ev_q <= 1'b0;
        else
            link_ev_q <= conv_done_i;
    end

    // [R20] eight bits, no clear on match
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ev_cnt_q <= 8'h00;
        else if (link_ev_q)
            ev_cnt_q <= ev_cnt_q + 8'h01;
    end

    // [R10] compare match at 128
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            match_q <= 1'b0;
            wrap_q  <= 1'b0;
        end
        else
        begin
            match_q <= link_ev_q && (ev_cnt_q == `PCS_HALF_MATCH - 8'h01);
            wrap_q  <= link_ev_q && (ev_cnt_q == 8'hFF);
        end
    end

    // status is write-one-to-clear; a set in the same cycle wins
    assign clr_first  = wr_acc && reg_hit(paddr_i, `PCS_STAT_OFS)
                     && pwdata_i[`PCS_STAT_FIRST_BIT];
    assign clr_second = wr_acc && reg_hit(paddr_i, `PCS_STAT_OFS)
                     && pwdata_i[`PCS_STAT_SECOND_BIT];

    // [R11] first half ready
    // [R12] second half ready
    // [R17] flags held until software clears
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            first_q  <= 1'b0;
            second_q <= 1'b0;
        end
        else
        begin
            first_q  <= match_q || (first_q && !clr_first);
            second_q <= wrap_q || (second_q && !clr_second);
        end
    end

    assign pready_o              = pready_q;
    assign prdata_o              = prdata_q;
    assign pslverr_o             = pslverr_q;
    assign conv_start_o          = conv_start_q;
    assign conv_chan_o           = `PCS_CONV_CHANNEL;
    assign mem_wr_o              = mem_wr_q;
    assign mem_addr_o            = mem_addr_q;
    assign mem_src_addr_o        = `PCS_SRC_ADDR;
    assign mem_wdata_o           = sample_q;
    assign xfer_irq_o            = xfer_irq_q;
    assign half_full_match_irq_o = match_q;
    assign buffer_wrap_irq_o     = wrap_q;
    assign first_half_ready_o    = first_q;
    assign second_half_ready_o   = second_q;

    sequence fetch_then_write_s;
        (xf_q == PCS_XF_FETCH) ##1 mem_wr_o;
    endsequence

    // [R1] period count
    period_exact_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R1]
        (enable_q && !tick) |=> timer_q == $past(timer_q) + TW'(1))
        else $error("timer skipped a count");
    // [R2] start only on trigger
    start_on_tick_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R2]
        conv_start_o |-> $past(tick) ##1 !conv_start_o)
        else $error("conversion start not from trigger");
    // [R3] channel
    chan_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R3]
        conv_start_o |-> conv_chan_o == 4'h0)
        else $error("wrong converter channel");
    // [R14] fetch before write
    fetch_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R14]
        (xf_q == PCS_XF_IDLE && conv_done_i) |=> fetch_then_write_s)
        else $error("transfer skipped its fetch");
    // [R7] addresses
    dest_addr_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R7]
        $rose(mem_wr_o) |-> mem_addr_o == dst_base_q + {23'h0, idx_q, 1'b0}
            && mem_src_addr_o == 32'h0008_9020)
        else $error("transfer address wrong");
    // [R5] wrap
    repeat_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R5]
        (xfer_done && idx_q == 8'hFF) |=> idx_q == 8'h00)
        else $error("buffer did not wrap");
    // [R8] irq per transfer
    xfer_irq_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R8]
        (mem_wr_o && mem_ready_i) |=> xfer_irq_o ##1 !xfer_irq_o)
        else $error("transfer interrupt missing");
    // [R10] [R11] match
    half_match_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R11]
        (link_ev_q && ev_cnt_q == 8'h7F) |=> half_full_match_irq_o ##1 first_half_ready_o)
        else $error("first half not flagged");
    // [R12] overflow
    wrap_flag_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R12]
        (link_ev_q && ev_cnt_q == 8'hFF) |=> buffer_wrap_irq_o ##1 second_half_ready_o)
        else $error("second half not flagged");
    // [R9] count per conversion
    link_count_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R9]
        conv_done_i |=> ##1 ev_cnt_q == $past(ev_cnt_q, 1) + 8'h01)
        else $error("conversion not counted");

endmodule : pcs_capture

`default_nettype wire

// >>> inc/pcs_params.svh
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// clock and sample timing
`define PCS_CLK_HZ          250_000_000
`define PCS_SAMPLE_HZ       8000
`define PCS_PERIOD_CYCLES   (`PCS_CLK_HZ / `PCS_SAMPLE_HZ)

// transfer channel
`define PCS_SRC_ADDR        32'h0008_9020
`define PCS_DST_ADDR        32'h0000_4000
`define PCS_XFER_COUNT      256
`define PCS_HALF_MATCH      8'h80
`define PCS_CONV_CHANNEL    4'h0

// register byte offsets
`define PCS_CTRL_OFS        12'h000
`define PCS_STAT_OFS        12'h004
`define PCS_COUNT_OFS       12'h008
`define PCS_DST_OFS         12'h00C
`define PCS_SRC_OFS         12'h010

// field positions
`define PCS_CTRL_EN_BIT     0
`define PCS_STAT_FIRST_BIT  0
`define PCS_STAT_SECOND_BIT 1

// reset values
`define PCS_CTRL_RST        32'h0000_0000

`endif

// >>> inc/pcs_pkg.sv
`default_nettype none

package pcs_pkg;

    typedef logic [31:0] pcs_word_t;
    typedef logic [15:0] pcs_half_t;

    typedef enum logic [1:0] {
        PCS_XF_IDLE  = 2'b00,
        PCS_XF_FETCH = 2'b01,
        PCS_XF_WRITE = 2'b10
    } pcs_xfer_state_t;

endpackage : pcs_pkg

`default_nettype wire

// >>> dv/pcs_conv_ram_model.sv
`default_nettype none

module pcs_conv_ram_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // converter side
    input  wire logic        conv_start_i,
    output logic             conv_done_o,
    output logic [11:0]      conv_data_o,
    // ram side
    input  wire logic        mem_wr_i,
    input  wire logic [3:0]  stall_i,
    output logic             mem_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly_q;
    logic       busy_q;
    logic [7:0] cnt_q;
    logic [3:0] wait_q;

    // 12-bit result
    // between results the data lines toggle, so a late read is seen
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_q      <= 1'b0;
            dly_q       <= 2'd0;
            cnt_q       <= 8'h00;
            conv_done_o <= 1'b0;
            conv_data_o <= 12'h000;
        end
        else if (busy_q && dly_q == 2'd2)
        begin
            busy_q      <= 1'b0;
            conv_done_o <= 1'b1;
            conv_data_o <= {4'ha, cnt_q};
            cnt_q       <= cnt_q + 8'h01;
        end
        else
        begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~conv_data_o;
            dly_q       <= busy_q ? dly_q + 2'd1 : 2'd0;
            busy_q      <= busy_q | conv_start_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_ready_o <= 1'b0;
            wait_q      <= 4'h0;
        end
        else if (mem_wr_i && !mem_ready_o && wait_q < stall_i)
            wait_q <= wait_q + 4'h1;
        else
        begin
            mem_ready_o <= mem_wr_i && !mem_ready_o;
            wait_q      <= 4'h0;
        end
    end
endmodule : pcs_conv_ram_model

`default_nettype wire

// >>> dv/tb_top.sv
`include "pcs_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    localparam int unsigned PER = 16;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    pcs_word_t   pwdata  = 32'h0000_0000;
    logic [3:0]  stall   = 4'h0;
    logic        pready, pslverr, conv_start, conv_done, mem_wr, mem_ready;
    logic        xirq, hirq, wirq, fh, sh;
    logic [3:0]  conv_chan;
    logic [11:0] conv_data;
    pcs_word_t   prdata, mem_addr, mem_src, rdata;
    pcs_half_t   mem_wdata;
    logic        rerr;
    int          errors = 0;
    int          checked = 0;
    int          n_wr = 0;
    int          n_irq = 0;
    int          n_half = 0;
    int          n_wrap = 0;
    int          n_start = 0;
    int          cyc = 0;
    int          last = 0;

    always #2 clock_i = ~clock_i;

    pcs_capture #(.PERIOD_CYCLES(PER)) dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .conv_start_o(conv_start),
        .conv_chan_o(conv_chan), .conv_done_i(conv_done), .conv_data_i(conv_data),
        .mem_wr_o(mem_wr), .mem_addr_o(mem_addr), .mem_src_addr_o(mem_src),
        .mem_wdata_o(mem_wdata), .mem_ready_i(mem_ready), .xfer_irq_o(xirq),
        .half_full_match_irq_o(hirq), .buffer_wrap_irq_o(wirq),
        .first_half_ready_o(fh), .second_half_ready_o(sh));

    pcs_conv_ram_model far (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .conv_start_i(conv_start),
        .conv_done_o(conv_done), .conv_data_o(conv_data), .mem_wr_i(mem_wr),
        .stall_i(stall), .mem_ready_o(mem_ready));

    task automatic chk(input pcs_word_t got, input pcs_word_t exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic apb(input logic wr, input logic [11:0] a, input pcs_word_t wd);
        @(posedge clock_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1)
            @(posedge clock_i);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input pcs_word_t exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask : rd

    task automatic wait_wr(input int n);
        // counters move on rising edges; look at them between edges to avoid a race
        while (n_wr < n)
            @(negedge clock_i);
        repeat (2) @(negedge clock_i);
    endtask : wait_wr

    task summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // watches the converter and ram sides at every rising edge
    always @(posedge clock_i)
    begin
        cyc++;
        if (conv_start === 1'b1)
        begin
            if (n_start > 0)
                chk(pcs_word_t'(cyc - last), PER);
            last = cyc;
            n_start++;
        end
        if (mem_wr === 1'b1 && mem_ready === 1'b1)
        begin
            chk(mem_addr, pcs_word_t'(`PCS_DST_ADDR + 2 * (n_wr % 256)));
            chk({16'h0, mem_wdata}, {24'h00_000a, n_wr[7:0]});
            n_wr++;
        end
        n_irq  += (xirq === 1'b1);
        n_half += (hirq === 1'b1);
        n_wrap += (wirq === 1'b1);
    end

    initial
    begin
        #80000;
        errors++;
        summarize();
    end

    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        chk({28'h0, conv_chan}, 32'h0000_0000);
        chk(mem_src, `PCS_SRC_ADDR);
        rd(`PCS_CTRL_OFS, `PCS_CTRL_RST);
        rd(`PCS_SRC_OFS, `PCS_SRC_ADDR);
        rd(`PCS_DST_OFS, `PCS_DST_ADDR);
        rd(`PCS_STAT_OFS, 32'h0000_0000);
        rd(12'h020, 32'h0000_0000);
        chk1(rerr, 1'b1);
        apb(1'b1, 12'h020, 32'hffff_ffff);
        chk1(rerr, 1'b1);
        apb(1'b1, `PCS_CTRL_OFS, 32'h0000_0001);
        apb(1'b1, `PCS_DST_OFS, 32'h0000_8000);
        rd(`PCS_DST_OFS, `PCS_DST_ADDR);
        wait_wr(128);
        chk1(fh, 1'b1);
        chk1(sh, 1'b0);
        chk(n_half, 1);
        chk(n_wrap, 0);
        chk(n_irq, n_wr);
        rd(`PCS_STAT_OFS, 32'h0000_0001);
        apb(1'b1, `PCS_STAT_OFS, 32'h0000_0001);
        rd(`PCS_STAT_OFS, 32'h0000_0000);
        // slow ram for the second half
        stall <= 4'h5;
        wait_wr(256);
        chk1(sh, 1'b1);
        chk1(fh, 1'b0);
        chk(n_wrap, 1);
        chk(n_half, 1);
        rd(`PCS_STAT_OFS, 32'h0000_0002);
        apb(1'b1, `PCS_STAT_OFS, 32'h0000_0002);
        apb(1'b1, `PCS_CTRL_OFS, 32'h0000_0000);
        repeat (40) @(posedge clock_i);
        n_start = 0;
        repeat (3 * PER) @(posedge clock_i);
        chk(n_start, 0);
        // destination base may only move while paused
        apb(1'b1, `PCS_DST_OFS, 32'h0000_8000);
        rd(`PCS_DST_OFS, 32'h0000_8000);
        apb(1'b1, `PCS_DST_OFS, `PCS_DST_ADDR);
        rd(`PCS_COUNT_OFS, {16'h0, n_wr[7:0], n_wr[7:0]});
        apb(1'b1, `PCS_CTRL_OFS, 32'h0000_0001);
        wait_wr(n_wr + 8);
        chk(n_irq, n_wr);
        chk(n_start, 8);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
